//--- src/sadc_conversion_cycle.sv
`timescale 1ns/1ps

module sadc_conversion_cycle #(
  parameter int Width = sadc_pkg::ResultWidth
) (
  input  wire logic                              clk,
  input  wire logic                              reset_n,
  input  wire logic                              frameSelect_n,
  input  wire logic                              serialClock,
  input  wire logic                              serialIn,
  input  wire logic [sadc_pkg::ChannelCount-1:0][Width-1:0] analogLevel,
  output logic                                   serialOut,
  output logic                                   serialOutEn,
  output logic      [sadc_pkg::ChannelCount-1:0] muxSelect,
  output logic                                   samplerConnected,
  output logic      [Width-1:0]                  lastResult,
  output logic      [sadc_pkg::ChanWidth-1:0]    activeChannel
);
  import sadc_pkg::*;

  sadc_phase_t        phase_q;
  logic               sclkPrev_q;
  logic               selPrev_q;
  logic [3:0]         riseCount_q;
  logic [3:0]         fallCount_q;
  logic [7:0]         control_q;
  logic [ChanWidth-1:0] nextChannel_q;
  logic [ChanWidth-1:0] channel_q;
  logic [Width-1:0]   sample_q;
  logic               dout_q;
  logic [Width-1:0]   sarWord;
  logic               sarDone;
  logic               sarDonePrev_q;
  logic               sarStart;
  logic               sarFinish;
  logic               riseEdge;
  logic               fallEdge;
  logic               frameStart;
  logic               retrack;
  logic               inFrame;
  logic [3:0]         bitSel;

  assign inFrame    = !frameSelect_n;
  assign riseEdge   = inFrame && serialClock && !sclkPrev_q;
  // A frame opened with the clock low counts as the first falling edge.
  assign frameStart = inFrame && selPrev_q;
  assign fallEdge   = inFrame && !frameStart && !serialClock && sclkPrev_q;
  assign sarStart   = fallEdge && fallCount_q == 4'(TrackClocks);
  // The fall after the sixteenth rise ends one cycle and tracks again.
  assign retrack    = fallEdge && fallCount_q == 4'h0;
  // Result bits leave MSB first from the fifth fall; each is settled in the
  // search word well before its fall, so the word is read bit by bit.
  assign bitSel     = 4'(Width - 1) - (fallCount_q - FirstDataEdge);
  assign sarFinish  = sarDone && !sarDonePrev_q;

  function automatic logic [ChannelCount-1:0] decodeChan(
    input logic [ChanWidth-1:0] ch
  );
    decodeChan = '0;
    decodeChan[ch] = 1'b1;
  endfunction : decodeChan

  // Both pins are compared with their value one clock earlier; a serial
  // phase shorter than one system clock could be missed.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      // Following the pin in reset keeps a false edge out of the release.
      sclkPrev_q <= serialClock;
      selPrev_q  <= 1'b1;
    end else begin
      sclkPrev_q <= serialClock;
      selPrev_q  <= frameSelect_n;
    end
  end

  // Edge counters wrap every 16 so continuous frames restart tracking.
  always_ff @(posedge clk) begin
    if (!reset_n || !inFrame) begin
      riseCount_q <= 4'h0;
      fallCount_q <= 4'h0;
    end else begin
      if (riseEdge) begin
        riseCount_q <= riseCount_q + 4'h1;
      end
      if (frameStart && !serialClock) begin
        fallCount_q <= 4'h1;
      end else if (fallEdge) begin
        fallCount_q <= fallCount_q + 4'h1;
      end
    end
  end

  // Idle waits for the frame; the cycle then alternates track and hold
  // until the frame select rises, which returns to idle from any phase.
  always_ff @(posedge clk) begin
    if (!reset_n || !inFrame) begin
      phase_q <= SadcIdle;
    end else begin
      case (phase_q)
        SadcIdle: begin
          if (frameStart) begin
            phase_q <= SadcTrack;
          end
        end
        SadcTrack: begin
          if (sarStart) begin
            phase_q <= SadcHold;
          end
        end
        SadcHold: begin
          if (retrack) begin
            phase_q <= SadcTrack;
          end
        end
        default: phase_q <= SadcIdle;
      endcase
    end
  end

  // Only the first eight rises of a cycle carry control bits; later bits
  // of the input stream are ignored.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      control_q     <= 8'h00;
      nextChannel_q <= ResetChannel;
    end else if (riseEdge && riseCount_q <= ControlLastEdge) begin
      control_q <= {control_q[6:0], serialIn};
      if (riseCount_q == ControlLastEdge) begin
        // Bit 0 is still on the pin, so the field sits one place lower.
        nextChannel_q <=
          control_q[ChanFieldLsb+1:ChanFieldLsb-1];
      end
    end
  end

  // The channel word takes effect at the next cycle, not the current one.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      channel_q <= ResetChannel;
    end else if (phase_q == SadcIdle && frameStart) begin
      channel_q <= nextChannel_q;
    end else if (phase_q == SadcHold && retrack) begin
      channel_q <= nextChannel_q;
    end
  end

  // Tracking follows the input; the value is frozen on the hold edge.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      sample_q <= ResetResult;
    end else if (phase_q == SadcTrack) begin
      sample_q <= analogLevel[channel_q];
    end
  end

  // The search takes Width system clocks after the fourth fall, so the
  // serial clock must leave that many system clocks before the sixteenth
  // fall; the result register follows as soon as the search is done.
  sadc_sar_core #(
    .Width (Width)
  ) u_sar (
    .clk     (clk),
    .reset_n (reset_n),
    .start   (sarStart),
    .step    (phase_q == SadcHold),
    .sample  (sample_q),
    .result  (sarWord),
    .done    (sarDone)
  );

  // Straight binary code; level units are supply/4096 with half-step offset.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      lastResult <= ResetResult;
    end else if (sarFinish) begin
      lastResult <= sarWord;
    end
  end

  // Done idles high, so its delayed copy also resets high and a reset alone
  // never looks like a finished search.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      sarDonePrev_q <= 1'b1;
    end else begin
      sarDonePrev_q <= sarDone;
    end
  end

  // A frame opened with the clock low shifts a lead zero at frame start.
  always_ff @(posedge clk) begin
    if (!reset_n || !inFrame) begin
      dout_q <= 1'b0;
    end else if (fallEdge || (frameStart && !serialClock)) begin
      if (fallCount_q >= FirstDataEdge) begin
        dout_q <= sarWord[bitSel];
      end else begin
        dout_q <= 1'b0;
      end
    end
  end

  assign serialOut        = dout_q;
  assign serialOutEn      = inFrame;
  assign samplerConnected = (phase_q == SadcTrack);
  assign muxSelect        = (phase_q == SadcTrack) ? decodeChan(channel_q)
                                                   : '0;
  assign activeChannel    = channel_q;

endmodule : sadc_conversion_cycle

//--- src/sadc_pkg.sv
package sadc_pkg;

  localparam int          ChannelCount     = 8;
  localparam int          ChanWidth        = 3;
  localparam int          ResultWidth      = 12;
  localparam int          CycleClocks      = 16;
  localparam int          TrackClocks      = 3;
  localparam int          HoldClocks       = 13;
  localparam int          LeadZeros        = 4;
  localparam int          ControlBits      = 8;
  localparam int          ChanFieldLsb     = 3;
  localparam logic [3:0]  ControlLastEdge  = 4'h7;
  localparam logic [3:0]  FirstDataEdge    = 4'h4;
  localparam logic [2:0]  ResetChannel     = 3'h0;
  localparam logic [11:0] ResetResult      = 12'h000;
  localparam logic [11:0] FullScaleCode    = 12'hfff;

  typedef enum logic [2:0] {
    SadcIdle  = 3'b001,
    SadcTrack = 3'b010,
    SadcHold  = 3'b100
  } sadc_phase_t;

endpackage : sadc_pkg

//--- src/sadc_sar_core.sv
`timescale 1ns/1ps

// Successive-approximation search: one trial bit per step, MSB first.
module sadc_sar_core #(
  parameter int Width = 12
) (
  input  wire logic             clk,
  input  wire logic             reset_n,
  input  wire logic             start,
  input  wire logic             step,
  input  wire logic [Width-1:0] sample,
  output logic      [Width-1:0] result,
  output logic                  done
);

  logic [Width-1:0] trialMask_q;
  logic [Width-1:0] word_q;
  logic [Width-1:0] candidate;

  assign candidate = word_q | trialMask_q;
  assign result    = word_q;
  assign done      = (trialMask_q == '0);

  // The comparator balances when the DAC word no longer exceeds the sample.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      trialMask_q <= '0;
      word_q      <= '0;
    end else if (start) begin
      trialMask_q <= {1'b1, {(Width-1){1'b0}}};
      word_q      <= '0;
    end else if (step && trialMask_q != '0) begin
      if (candidate <= sample) begin
        word_q <= candidate;
      end
      trialMask_q <= trialMask_q >> 1;
    end
  end

endmodule : sadc_sar_core

//--- testbench/sadc_checker.sv
`timescale 1ns/1ps
module sadc_checker #(
  parameter int Width = 12
) (
  input wire logic                              clk,
  input wire logic                              reset_n,
  input wire logic                              frameSelect_n,
  input wire logic                              serialClock,
  input wire logic                              serialOut,
  input wire logic                              serialOutEn,
  input wire logic [sadc_pkg::ChannelCount-1:0] muxSelect,
  input wire logic                              samplerConnected,
  input wire logic [Width-1:0]                  lastResult
);
  logic       sclkQ;
  logic [4:0] fallQ;
  wire        rise = serialClock && !sclkQ;
  // Phase is judged at each serial rise, when the design has long settled.
  always_ff @(posedge clk) sclkQ <= serialClock;
  always_ff @(posedge clk) begin
    if (frameSelect_n) fallQ <= 5'h00;
    else if (sclkQ && !serialClock) fallQ <= fallQ[4] ? 5'h01 : fallQ + 5'h01;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  property p_en; serialOutEn == !frameSelect_n; endproperty
  a_en: assert property (p_en) else $error("output enable");
  property p_one; samplerConnected |-> $onehot(muxSelect); endproperty
  a_one: assert property (p_one) else $error("mux not one-hot");
  property p_off; !samplerConnected |-> muxSelect == '0; endproperty
  a_off: assert property (p_off) else $error("mux open in hold");
  property p_trk;
    rise && fallQ inside {[1:3]} |-> samplerConnected;
  endproperty
  a_trk: assert property (p_trk) else $error("not tracking");
  property p_hld; rise && fallQ >= 4 |-> !samplerConnected; endproperty
  a_hld: assert property (p_hld) else $error("not holding");
  property p_zero; rise && fallQ inside {[1:4]} |-> !serialOut; endproperty
  a_zero: assert property (p_zero) else $error("lead bit");
  property p_bit;
    rise && fallQ >= 5 |-> serialOut == lastResult[16 - fallQ];
  endproperty
  a_bit: assert property (p_bit) else $error("result bit");
  property p_keep;
    frameSelect_n && $past(frameSelect_n) |-> $stable(lastResult);
  endproperty
  a_keep: assert property (p_keep) else $error("result moved");
endmodule : sadc_checker

bind sadc_conversion_cycle sadc_checker #(.Width(Width)) sadc_checker_inst (
  .clk(clk), .reset_n(reset_n), .frameSelect_n(frameSelect_n),
  .serialClock(serialClock), .serialOut(serialOut),
  .serialOutEn(serialOutEn), .muxSelect(muxSelect),
  .samplerConnected(samplerConnected), .lastResult(lastResult));

//--- testbench/sadc_host_model.sv
`timescale 1ns/1ps
// Serial host, 12 system clocks per serial period; the clock idles high.
module sadc_host_model (
  input  wire logic clk,
  output logic      frameSelect_n,
  output logic      serialClock,
  output logic      serialIn,
  input  wire logic serialOut,
  input  wire logic serialOutEn
);
  initial begin
    frameSelect_n = 1'b1;
    serialClock = 1'b1;
    serialIn = 1'b0;
  end
  task automatic run_frame(input logic [15:0] ctl, output logic [31:0] got);
    got = '0;
    @(posedge clk);
    frameSelect_n <= 1'b0;
    repeat (6) @(posedge clk);
    for (int i = 0; i < 32; i++) begin
      serialClock <= 1'b0;
      serialIn <= (i % 16 < 8) ? ctl[15 - i % 16 - 8 * (i / 16)]
                               : 1'b0;
      repeat (5) @(posedge clk);
      @(negedge clk);
      // A released output reads as the inverse of the last bit.
      got = {got[30:0], serialOutEn ? serialOut : ~got[0]};
      @(posedge clk);
      serialClock <= 1'b1;
      repeat (6) @(posedge clk);
    end
    frameSelect_n <= 1'b1;
    serialIn <= ~serialIn;
    repeat (4) @(posedge clk);
  endtask : run_frame
endmodule : sadc_host_model

//--- testbench/tb_sadc_conversion_cycle.sv
`timescale 1ns/1ps
module tb_sadc_conversion_cycle;
  import sadc_pkg::*;
  logic                                     clk = 1'b0;
  logic                                     reset_n = 1'b0;
  logic                                     fsN, sclk, sdi, sdo, sdoEn, smp;
  logic [ChannelCount-1:0][ResultWidth-1:0] lvl;
  logic [ChannelCount-1:0]                  mux;
  logic [ResultWidth-1:0]                   last;
  logic [ChanWidth-1:0]                     chan;
  logic [31:0]                              w;
  int                                       n_errors = 0;
  int                                       samples_checked = 0;
  always #12.5 clk = ~clk;
  sadc_conversion_cycle sadc_conversion_cycle_inst (
    .clk(clk), .reset_n(reset_n), .frameSelect_n(fsN), .serialClock(sclk),
    .serialIn(sdi), .analogLevel(lvl), .serialOut(sdo), .serialOutEn(sdoEn),
    .muxSelect(mux), .samplerConnected(smp), .lastResult(last),
    .activeChannel(chan));
  sadc_host_model sadc_host_model_inst (
    .clk(clk), .frameSelect_n(fsN), .serialClock(sclk), .serialIn(sdi),
    .serialOut(sdo), .serialOutEn(sdoEn));
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got %h want %h", $time, got, exp);
    end
  endtask : check
  task automatic do_reset();
    @(posedge clk);
    reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    @(negedge clk);
    check({sdoEn, smp, sdo, mux, chan, 2'h0}, 16'h0000);
    check({4'h0, last}, 16'h0000);
    $display("test reset done");
  endtask : do_reset
  task automatic t_channels();
    logic [2:0]  prev;
    logic [2:0]  ch;
    logic [15:0] ctl;
    prev = ResetChannel;
    for (int k = 0; k < 9; k++) begin
      ch = 3'(7 - k);
      // Don't-care bits set to one must not disturb the channel field.
      ctl = {2'b11, ch, 3'b111, 2'b00, 3'(k), 3'b000};
      sadc_host_model_inst.run_frame(ctl, w);
      check(w[31:16], {4'h0, lvl[prev]});
      check(w[15:0], {4'h0, lvl[ch]});
      check({4'h0, last}, {4'h0, lvl[ch]});
      check({13'h0, chan}, {13'h0, ch});
      prev = 3'(k);
    end
    $display("test channels done");
  endtask : t_channels
  task automatic t_continuous();
    sadc_host_model_inst.run_frame({8'h18, 8'h30}, w);
    check(w[31:16], {4'h0, lvl[0]});
    check(w[15:0], {4'h0, lvl[3]});
    @(posedge clk);
    lvl[6] <= 12'h800;
    sadc_host_model_inst.run_frame(16'h0000, w);
    check(w[31:16], 16'h0800);
    check(w[15:0], {4'h0, lvl[0]});
    $display("test continuous done");
  endtask : t_continuous
  task automatic give_verdict();
    $display("compared %0d mismatched %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : give_verdict
  initial begin
    for (int i = 0; i < 8; i++) lvl[i] = 12'h5a5 + 12'(i * 12'h111);
    lvl[2] = 12'h000;
    lvl[7] = FullScaleCode;
    do_reset();
    t_channels();
    t_continuous();
    do_reset();
    sadc_host_model_inst.run_frame(16'h0000, w);
    check(w[31:16], {4'h0, lvl[0]});
    give_verdict();
  end
endmodule : tb_sadc_conversion_cycle
